// ### hw/rxaf_pkg.sv
// Purpose: shared constants and types of the receive address filter and wake detector
// Assumes: APB register access, one clock, bytes arrive from the MAC receive path
// Notes: all offsets are byte addresses of aligned 32-bit words
package rxaf_pkg;
    // ==================================================================
    // register map
    localparam logic [7:0] RXAF_OFS_MAC_CTRL = 8'h00;
    localparam logic [7:0] RXAF_OFS_ADDR_HI = 8'h04;
    localparam logic [7:0] RXAF_OFS_ADDR_LO = 8'h08;
    localparam logic [7:0] RXAF_OFS_HASH_HI = 8'h0c;
    localparam logic [7:0] RXAF_OFS_HASH_LO = 8'h10;
    localparam logic [7:0] RXAF_OFS_WAKE_PORT = 8'h14;
    localparam logic [7:0] RXAF_OFS_WAKE_CSR = 8'h18;
    localparam logic [7:0] RXAF_OFS_FRAME_STAT = 8'h1c;

    // ==================================================================
    // field positions
    localparam int RXAF_CTL_HASH_ONLY = 0;
    localparam int RXAF_CTL_HASH_PERF = 1;
    localparam int RXAF_CTL_INVERSE = 2;
    localparam int RXAF_CTL_ALL = 3;
    localparam int RXAF_CTL_PASS_MC = 4;
    localparam int RXAF_CSR_ENABLE = 0;
    localparam int RXAF_CSR_RECEIVED = 1;
    localparam int RXAF_CSR_IRQ_EN = 2;
    localparam int RXAF_CSR_PME_EN = 3;
    localparam int RXAF_CSR_REDUCED = 8;
    localparam int RXAF_CMD_ENABLE = 0;
    localparam int RXAF_CMD_MCAST = 3;
    localparam int RXAF_WORD_CMD = 4;
    localparam int RXAF_WORD_OFFSET = 5;
    localparam int RXAF_WORD_CRC_LO = 6;
    localparam int RXAF_WORD_CRC_HI = 7;

    // ==================================================================
    // reset values and counts
    localparam logic [31:0] RXAF_RST_WORD = 32'h0000_0000;
    localparam logic [2:0] RXAF_RST_PTR = 3'h0;
    localparam logic [8:0] RXAF_POS_MAX = 9'h1ff;
    localparam logic [8:0] RXAF_DA_BYTES = 9'h006;
    localparam logic [8:0] RXAF_MASK_BITS = 9'h01f;
    localparam logic [31:0] RXAF_CRC32_SEED = 32'hffff_ffff;
    localparam logic [31:0] RXAF_CRC32_POLY = 32'hedb8_8320;
    localparam logic [15:0] RXAF_CRC16_SEED = 16'hffff;
    localparam logic [15:0] RXAF_CRC16_POLY = 16'ha001;

    // ==================================================================
    // types
    typedef enum logic [1:0] {
        RXAF_IDLE = 2'b01,
        RXAF_FRAME = 2'b10
    } rxaf_state_t;

    typedef struct packed {
        logic valid;
        logic sof;
        logic eof;
        logic [7:0] data;
    } rxaf_beat_t;

    typedef struct packed {
        logic done;
        logic pass;
        logic wake;
    } rxaf_result_t;
endpackage

// ### hw/rxaf_wake_store.sv
// Purpose: eight-word store behind the wake filter port
// Assumes: writer supplies the word index and the word already merged under byte strobes
// Notes: all words are visible in parallel; read data is registered
`timescale 1ns/1ps
module rxaf_wake_store
    import rxaf_pkg::*;
(
    input wire logic clk, // bus clock
    input wire logic rst_n, // async reset, active low
    input wire logic wr_en, // write strobe
    input wire logic [2:0] idx, // word index
    input wire logic [31:0] wr_data, // merged write word
    output logic [7:0][31:0] words, // all filter words
    output logic [31:0] rd_q // word at idx, registered
);
    logic [7:0][31:0] words_d;
    logic [31:0] rd_d;

    // ==================================================================
    // next values
    always_comb begin
        words_d = words;
        if (wr_en) begin
            words_d[idx] = wr_data;
        end
        rd_d = words[idx];
    end

    // registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            words <= '0;
            rd_q <= RXAF_RST_WORD;
        end else begin
            words <= words_d;
            rd_q <= rd_d;
        end
    end
endmodule

// ### hw/rxaf_top.sv
// Purpose: receive destination address filter and wake frame detector
// Assumes: receive bytes come on pclk, one byte per valid beat
// Notes: zero-wait APB slave; wake filter words loaded through one port
//
// Decided for this implementation: the register offsets and the APB slave port.
`timescale 1ns/1ps

// Overview of operation
// - perfect mode passes only destination equal to station address
// - hash index is top six bits of CRC over destination
// - index msb picks high or low hash word, five bits pick bit
// - hash-only mode hashes every destination, unicast or multicast
// - hash-perfect: unicast exact compare, multicast through hash table
// - inverse mode passes destinations unlike station address, rejects equal
// - pass-all-multicast accepts every multicast frame in any mode
// - accept-all passes every frame, broadcast included
// - wake enable stops normal reception, frames only checked for patterns
// - wake frame sets received flag, optionally host irq or power event
// - clearing wake enable returns to normal reception unless reduced power is high
// - wake frame: passes the address filter and any enabled filter matches
// - mask bit j, for j up to 30, includes byte offset plus j in the pattern CRC
// - command bit 3 picks multicast or unicast destinations
// - command bit 0 enables the filter, bits 2:1 reserved
// - reduced power forces wake detection on regardless of enable
// - port words: four masks, command, offsets, two CRC words
// - mode bits select perfect, hash-perfect, hash-only or inverse
// - eight-bit offset, zero is first destination byte
// - sixteen-bit expected CRC equality marks a wake frame
module rxaf_top
    import rxaf_pkg::*;
(
    input wire logic pclk, // bus and receive clock
    input wire logic presetn, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    input wire logic [3:0] pstrb, // apb byte strobes
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error on unmapped address
    input wire rxaf_beat_t rx_beat, // receive byte from mac
    input wire logic reduced_power, // low power state from power logic
    output rxaf_result_t result, // per-frame filter result
    output logic wake_mode, // detection mode active
    output logic host_irq, // wake interrupt level
    output logic power_event_out // power management event level
);
    // ==================================================================
    // helpers
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [31:0] crc32_byte(input logic [31:0] c,
                                               input logic [7:0] d);
        logic [31:0] r;
        r = c;
        for (int k = 0; k < 8; k++) begin
            r = (r[0] ^ d[k]) ? ((r >> 1) ^ RXAF_CRC32_POLY) : (r >> 1);
        end
        return r;
    endfunction

    function automatic logic [15:0] crc16_byte(input logic [15:0] c,
                                               input logic [7:0] d);
        logic [15:0] r;
        r = c;
        for (int k = 0; k < 8; k++) begin
            r = (r[0] ^ d[k]) ? ((r >> 1) ^ RXAF_CRC16_POLY) : (r >> 1);
        end
        return r;
    endfunction

    function automatic logic is_addr(input logic [7:0] a,
                                     input logic [7:0] ofs);
        return a == ofs;
    endfunction

    // ==================================================================
    // register bus
    logic [31:0] ctrl_q, ctrl_d, addr_hi_q, addr_hi_d, addr_lo_q, addr_lo_d;
    logic [31:0] hash_hi_q, hash_hi_d, hash_lo_q, hash_lo_d;
    logic [31:0] prdata_d, prdata_q;
    logic [3:0] csr_q, csr_d;
    logic [2:0] ptr_q, ptr_d;
    logic [7:0] stat_q, stat_d;
    logic [7:0][31:0] fw;
    logic [31:0] port_rd;
    logic wr, rd, mapped, port_wr;
    logic wake_set;

    assign wr = psel & penable & pwrite;
    assign rd = psel & penable & ~pwrite;
    assign pready = 1'b1;
    assign mapped = is_addr(paddr, RXAF_OFS_MAC_CTRL) | is_addr(paddr, RXAF_OFS_ADDR_HI)
        | is_addr(paddr, RXAF_OFS_ADDR_LO) | is_addr(paddr, RXAF_OFS_HASH_HI)
        | is_addr(paddr, RXAF_OFS_HASH_LO) | is_addr(paddr, RXAF_OFS_WAKE_PORT)
        | is_addr(paddr, RXAF_OFS_WAKE_CSR) | is_addr(paddr, RXAF_OFS_FRAME_STAT);
    assign pslverr = psel & penable & ~mapped;
    assign port_wr = wr & is_addr(paddr, RXAF_OFS_WAKE_PORT);
    assign prdata = prdata_q;

    // filter words live in the store; index walks with each port access
    rxaf_wake_store u_store (
        .clk(pclk),
        .rst_n(presetn),
        .wr_en(port_wr),
        .idx(ptr_q),
        .wr_data(merge(fw[ptr_q], pwdata, pstrb)),
        .words(fw),
        .rd_q(port_rd)
    );

    // next values of software state
    always_comb begin
        ctrl_d = ctrl_q;
        addr_hi_d = addr_hi_q;
        addr_lo_d = addr_lo_q;
        hash_hi_d = hash_hi_q;
        hash_lo_d = hash_lo_q;
        csr_d = csr_q;
        ptr_d = ptr_q;
        prdata_d = prdata_q;
        if (wr & mapped) begin
            if (is_addr(paddr, RXAF_OFS_MAC_CTRL)) ctrl_d = merge(ctrl_q, pwdata, pstrb);
            if (is_addr(paddr, RXAF_OFS_ADDR_HI)) addr_hi_d = merge(addr_hi_q, pwdata, pstrb);
            if (is_addr(paddr, RXAF_OFS_ADDR_LO)) addr_lo_d = merge(addr_lo_q, pwdata, pstrb);
            if (is_addr(paddr, RXAF_OFS_HASH_HI)) hash_hi_d = merge(hash_hi_q, pwdata, pstrb);
            if (is_addr(paddr, RXAF_OFS_HASH_LO)) hash_lo_d = merge(hash_lo_q, pwdata, pstrb);
            if (is_addr(paddr, RXAF_OFS_WAKE_CSR) && pstrb[0]) begin
                csr_d[RXAF_CSR_ENABLE] = pwdata[RXAF_CSR_ENABLE];
                csr_d[RXAF_CSR_IRQ_EN] = pwdata[RXAF_CSR_IRQ_EN];
                csr_d[RXAF_CSR_PME_EN] = pwdata[RXAF_CSR_PME_EN];
                if (pwdata[RXAF_CSR_RECEIVED]) begin
                    csr_d[RXAF_CSR_RECEIVED] = 1'b0; // write one to clear
                end
            end
        end
        // a detection in the clearing cycle must not be lost
        if (wake_set) begin
            csr_d[RXAF_CSR_RECEIVED] = 1'b1;
        end
        // eight port accesses fill masks, command, offsets, crcs in order
        if ((wr | rd) & is_addr(paddr, RXAF_OFS_WAKE_PORT)) begin
            ptr_d = ptr_q + 3'h1;
        end
        // read data sampled in setup so it is stable for the access phase
        if (psel & ~penable & ~pwrite) begin
            case (paddr)
                RXAF_OFS_MAC_CTRL: prdata_d = ctrl_q;
                RXAF_OFS_ADDR_HI: prdata_d = addr_hi_q;
                RXAF_OFS_ADDR_LO: prdata_d = addr_lo_q;
                RXAF_OFS_HASH_HI: prdata_d = hash_hi_q;
                RXAF_OFS_HASH_LO: prdata_d = hash_lo_q;
                RXAF_OFS_WAKE_PORT: prdata_d = port_rd;
                RXAF_OFS_WAKE_CSR: prdata_d = {23'h0, reduced_power, 4'h0, csr_q};
                RXAF_OFS_FRAME_STAT: prdata_d = {24'h0, stat_q};
                default: prdata_d = 32'h0000_0000;
            endcase
        end
    end

    // software state registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= RXAF_RST_WORD;
            addr_hi_q <= RXAF_RST_WORD;
            addr_lo_q <= RXAF_RST_WORD;
            hash_hi_q <= RXAF_RST_WORD;
            hash_lo_q <= RXAF_RST_WORD;
            csr_q <= 4'h0;
            ptr_q <= RXAF_RST_PTR;
            prdata_q <= RXAF_RST_WORD;
        end else begin
            ctrl_q <= ctrl_d;
            addr_hi_q <= addr_hi_d;
            addr_lo_q <= addr_lo_d;
            hash_hi_q <= hash_hi_d;
            hash_lo_q <= hash_lo_d;
            csr_q <= csr_d;
            ptr_q <= ptr_d;
            prdata_q <= prdata_d;
        end
    end

    // ==================================================================
    // frame path
    rxaf_state_t state_q, state_d;
    logic [8:0] pos_q, pos_d, pos;
    logic [47:0] da_q, da_d;
    logic [31:0] crc32_q, crc32_d, crc32_base;
    logic [3:0][15:0] c16_q, c16_d;
    logic [3:0] hit;
    logic [5:0] hidx;
    logic mc, match, hash_ok, addr_ok, norm_ok, eval, live;
    rxaf_result_t result_d;
    logic irq_d, pme_d;

    assign live = rx_beat.valid & (rx_beat.sof | state_q == RXAF_FRAME);
    assign pos = rx_beat.sof ? 9'h000 : pos_q;
    assign crc32_base = rx_beat.sof ? RXAF_CRC32_SEED : crc32_q;
    // reduced power keeps detection running whatever software set
    assign wake_mode = csr_q[RXAF_CSR_ENABLE] | reduced_power;

    // per-filter pattern CRC over masked bytes only
    for (genvar i = 0; i < 4; i++) begin : g_filt
        logic [15:0] base, nxt;
        logic [8:0] rel;
        logic sel;
        assign base = rx_beat.sof ? RXAF_CRC16_SEED : c16_q[i];
        assign rel = pos - {1'b0, fw[RXAF_WORD_OFFSET][8*i +: 8]};
        // bit 31 of the mask is never looked at
        assign sel = (pos >= {1'b0, fw[RXAF_WORD_OFFSET][8*i +: 8]})
            && (rel < RXAF_MASK_BITS) && fw[i][rel[4:0]];
        assign nxt = sel ? crc16_byte(base, rx_beat.data) : base;
        assign c16_d[i] = live ? nxt : c16_q[i];
        // reserved command bits 2:1 are ignored
        assign hit[i] = fw[RXAF_WORD_CMD][8*i + RXAF_CMD_ENABLE]
            && (fw[RXAF_WORD_CMD][8*i + RXAF_CMD_MCAST] == mc)
            && (nxt == fw[RXAF_WORD_CRC_LO + i/2][16*(i%2) +: 16]);
    end

    // destination capture, hash CRC and byte position
    always_comb begin
        state_d = state_q;
        pos_d = pos_q;
        da_d = da_q;
        crc32_d = crc32_q;
        if (live) begin
            state_d = rx_beat.eof ? RXAF_IDLE : RXAF_FRAME;
            pos_d = (pos == RXAF_POS_MAX) ? pos : pos + 9'h001;
            crc32_d = crc32_base;
            if (pos < RXAF_DA_BYTES) begin
                da_d[8*pos[2:0] +: 8] = rx_beat.data;
                crc32_d = crc32_byte(crc32_base, rx_beat.data);
            end
        end
        case (state_q)
            RXAF_IDLE, RXAF_FRAME: ;
            default: state_d = RXAF_IDLE;
        endcase
    end

    // address decision on the final beat of a frame
    always_comb begin
        eval = live & rx_beat.eof & (pos >= RXAF_DA_BYTES - 9'h001);
        mc = da_d[0];
        match = da_d == {addr_hi_q[15:0], addr_lo_q};
        hidx = crc32_d[31:26];
        hash_ok = hidx[5] ? hash_hi_q[hidx[4:0]] : hash_lo_q[hidx[4:0]];
        case ({ctrl_q[RXAF_CTL_INVERSE], ctrl_q[RXAF_CTL_HASH_ONLY],
               ctrl_q[RXAF_CTL_HASH_PERF]})
            3'b001: addr_ok = mc ? hash_ok : match;
            3'b011: addr_ok = hash_ok;
            3'b100: addr_ok = ~match;
            default: addr_ok = match;
        endcase
        if (ctrl_q[RXAF_CTL_PASS_MC] & mc) begin
            addr_ok = 1'b1;
        end
        if (ctrl_q[RXAF_CTL_ALL]) begin
            addr_ok = 1'b1;
        end
        norm_ok = addr_ok & ~wake_mode;
        wake_set = eval & wake_mode & addr_ok & (|hit);
        result_d.done = live & rx_beat.eof;
        result_d.pass = eval & norm_ok;
        result_d.wake = wake_set;
        stat_d = stat_q;
        if (eval) begin
            stat_d = {hidx, mc, addr_ok};
        end
        irq_d = csr_d[RXAF_CSR_RECEIVED] & csr_d[RXAF_CSR_IRQ_EN];
        pme_d = csr_d[RXAF_CSR_RECEIVED] & csr_d[RXAF_CSR_PME_EN];
    end

    // frame path registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= RXAF_IDLE;
            pos_q <= 9'h000;
            da_q <= 48'h0000_0000_0000;
            crc32_q <= RXAF_CRC32_SEED;
            c16_q <= '0;
            result <= '0;
            stat_q <= 8'h00;
            host_irq <= 1'b0;
            power_event_out <= 1'b0;
        end else begin
            state_q <= state_d;
            pos_q <= pos_d;
            da_q <= da_d;
            crc32_q <= crc32_d;
            c16_q <= c16_d;
            result <= result_d;
            stat_q <= stat_d;
            host_irq <= irq_d;
            power_event_out <= pme_d;
        end
    end
endmodule

// ### testbench/rxaf_properties.sv
// Purpose: port-level checks on the receive filter and wake detector
// Assumes: control and wake csr are written with byte strobe 0 set
// Notes: shadows a few control bits from apb writes
`timescale 1ns/1ps
module rxaf_properties
    import rxaf_pkg::*;
(
    input wire logic pclk, // clock
    input wire logic presetn, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access
    input wire logic pwrite, // apb direction
    input wire logic [7:0] paddr, // apb address
    input wire logic [31:0] pwdata, // apb write data
    input wire logic [3:0] pstrb, // apb strobes
    input wire logic [31:0] prdata, // apb read data
    input wire logic pready, // apb ready
    input wire logic pslverr, // apb error
    input wire rxaf_beat_t rx_beat, // receive byte
    input wire logic reduced_power, // low power state
    input wire rxaf_result_t result, // frame result
    input wire logic wake_mode, // detection mode
    input wire logic host_irq, // wake interrupt
    input wire logic power_event_out // power event
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [4:0] ctl_q, ctl_d;
    logic [3:0] csr_q, csr_d;
    logic [2:0] n_q, n_d;
    logic mc_q, mc_d, wr_ok;
    assign wr_ok = psel && penable && pwrite && pready && pstrb[0];
    // ==========================================================
    // shadow state; byte count saturates so short frames stay apart
    always_comb begin
        ctl_d = ctl_q;
        csr_d = csr_q;
        mc_d = mc_q;
        n_d = n_q;
        if (wr_ok && paddr == RXAF_OFS_MAC_CTRL)
            ctl_d = pwdata[4:0];
        if (wr_ok && paddr == RXAF_OFS_WAKE_CSR)
            csr_d = pwdata[3:0];
        if (rx_beat.valid && rx_beat.sof) begin
            mc_d = rx_beat.data[0];
            n_d = 3'h1;
        end else if (rx_beat.valid && n_q != 3'h6) begin
            n_d = n_q + 3'h1;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_q <= 5'h00;
            csr_q <= 4'h0;
            mc_q <= 1'b0;
            n_q <= 3'h0;
        end else begin
            ctl_q <= ctl_d;
            csr_q <= csr_d;
            mc_q <= mc_d;
            n_q <= n_d;
        end
    end
    // ==========================================================
    // checks
    property p_wm; wake_mode == (csr_q[0] || reduced_power); endproperty
    a_wm: assert property (p_wm) else $error("wake mode level wrong");
    property p_rp; reduced_power |-> wake_mode; endproperty
    a_rp: assert property (p_rp) else $error("reduced power without wake mode");
    property p_np; result.pass |-> !$past(wake_mode); endproperty
    a_np: assert property (p_np) else $error("frame passed in wake mode");
    property p_wk; result.wake |-> result.done && $past(wake_mode); endproperty
    a_wk: assert property (p_wk) else $error("wake result out of mode");
    property p_pr; result.done && ctl_q[3] && n_q == 3'h6 && !$past(wake_mode)
        |-> result.pass; endproperty
    a_pr: assert property (p_pr) else $error("accept all dropped a frame");
    property p_mc; result.done && ctl_q[4] && mc_q && n_q == 3'h6 && !$past(wake_mode)
        |-> result.pass; endproperty
    a_mc: assert property (p_mc) else $error("multicast dropped");
    property p_irq; result.wake && csr_q[2] |=> host_irq; endproperty
    a_irq: assert property (p_irq) else $error("host irq missing");
    property p_pme; result.wake && csr_q[3] |=> power_event_out; endproperty
    a_pme: assert property (p_pme) else $error("power event missing");
endmodule

bind rxaf_top rxaf_properties u_props (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .rx_beat, .reduced_power,
    .result, .wake_mode, .host_irq, .power_event_out);

// ### testbench/rxaf_mac_model.sv
// Purpose: receive path model feeding whole frames into the filter
// Assumes: payload byte k carries the value k
// Notes: data is inverted when released so a stale byte never looks held
`timescale 1ns/1ps
module rxaf_mac_model
    import rxaf_pkg::*;
(
    input wire logic clk, // receive clock
    output rxaf_beat_t beat // byte stream
);
    initial beat = '0;
    // ==========================================================
    // one frame: destination then counting payload
    task automatic send(input logic [47:0] da, input int len);
        for (int k = 0; k < len; k++) begin
            @(posedge clk);
            beat.valid <= 1'b1;
            beat.sof <= (k == 0);
            beat.eof <= (k == len - 1);
            beat.data <= (k < 6) ? da[47 - 8*k -: 8] : k[7:0];
        end
        @(posedge clk);
        beat.valid <= 1'b0;
        beat.eof <= 1'b0;
        beat.data <= ~beat.data;
    endtask
endmodule

// ### testbench/rxaf_tb_top.sv
// Purpose: register and frame tests of the receive filter
// Assumes: zero-wait apb, forty-byte frames
// Notes: expectations come from local crc and filter functions
`timescale 1ns/1ps
module rxaf_tb_top
    import rxaf_pkg::*;
;
    typedef struct packed {logic [7:0] cmd; logic bad; logic hit; logic [47:0] da;} rxaf_wc_t;
    localparam logic [47:0] STN = 48'h02_11_22_33_44_55;
    localparam logic [47:0] OTH = 48'h02_aa_bb_cc_dd_ee;
    localparam logic [47:0] MCA = 48'h01_00_5e_00_00_01;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [3:0] pstrb = 4'hf;
    logic pready, pslverr, wake_mode, host_irq, power_event_out, reduced_power = 1'b0;
    logic [63:0] htab;
    rxaf_beat_t rx_beat;
    rxaf_result_t result;
    int error_cnt = 0, total_checks = 0;
    always #10 pclk = ~pclk;
    rxaf_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rx_beat(rx_beat), .reduced_power(reduced_power),
        .result(result), .wake_mode(wake_mode), .host_irq(host_irq),
        .power_event_out(power_event_out));
    rxaf_mac_model u_mac (.clk(pclk), .beat(rx_beat));
    // ==========================================================
    // reporting
    task automatic end_of_test();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // ==========================================================
    // apb master; idles one cycle so no strobe is driven twice at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic e);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 50) begin
            n++;
            @(posedge pclk);
        end
        if (n >= 50) begin
            error_cnt++;
            end_of_test();
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        chk(q, x);
    endtask
    // ==========================================================
    // reference crc and filter
    function automatic logic [5:0] hidx(input logic [47:0] da);
        logic [31:0] c;
        c = RXAF_CRC32_SEED;
        for (int i = 0; i < 48; i++)
            c = (c[0] ^ da[40 - 8*(i/8) + i%8]) ? (c >> 1) ^ RXAF_CRC32_POLY : c >> 1;
        return c[31:26];
    endfunction
    function automatic logic [15:0] pcrc(input int first, input int cnt);
        logic [15:0] c;
        c = RXAF_CRC16_SEED;
        for (int k = first; k < first + cnt; k++)
            for (int b = 0; b < 8; b++)
                c = (c[0] ^ k[b]) ? (c >> 1) ^ RXAF_CRC16_POLY : c >> 1;
        return c;
    endfunction
    function automatic logic ref_pass(input logic [4:0] m, input logic [47:0] da);
        if (m[3] || (m[4] && da[40]))
            return 1'b1;
        case (m[2:0])
            3'b010: return da[40] ? htab[hidx(da)] : da == STN;
            3'b011: return htab[hidx(da)];
            3'b100: return da != STN;
            default: return da == STN;
        endcase
    endfunction
    task automatic frame(input logic [47:0] da, input logic ep, input logic ew);
        u_mac.send(da, 40);
        // result stands one cycle; read it at the edge that ends it
        @(posedge pclk);
        chk({29'h0, result}, {29'h0, 1'b1, ep, ew});
    endtask
    // eight port writes: masks, command, offsets, two crc words
    task automatic load(input logic [7:0] cmd, input logic [15:0] crc);
        wr(RXAF_OFS_WAKE_PORT, 32'h0000_0007);
        for (int i = 1; i < 4; i++)
            wr(RXAF_OFS_WAKE_PORT, 32'h0);
        wr(RXAF_OFS_WAKE_PORT, {24'h0, cmd});
        wr(RXAF_OFS_WAKE_PORT, 32'h0000_000e);
        wr(RXAF_OFS_WAKE_PORT, {16'h0, crc});
        wr(RXAF_OFS_WAKE_PORT, 32'h0);
    endtask
    // ==========================================================
    // main sequence
    initial begin
        logic [4:0] ctls [7];
        logic [47:0] das [4];
        rxaf_wc_t wt [7];
        logic [31:0] q;
        logic e;
        ctls = '{5'h00, 5'h02, 5'h03, 5'h04, 5'h10, 5'h12, 5'h08};
        das = '{STN, OTH, MCA, 48'hff_ff_ff_ff_ff_ff};
        wt[0] = '{8'h01, 1'b0, 1'b1, STN};
        wt[1] = '{8'h01, 1'b1, 1'b0, STN};
        wt[2] = '{8'h00, 1'b0, 1'b0, STN};
        wt[3] = '{8'h07, 1'b0, 1'b1, STN};
        wt[4] = '{8'h09, 1'b0, 1'b0, STN};
        wt[5] = '{8'h09, 1'b0, 1'b1, MCA};
        wt[6] = '{8'h01, 1'b0, 1'b0, OTH};
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(RXAF_OFS_WAKE_CSR, 32'h0);
        apb(1'b0, 8'h20, 32'h0, q, e);
        chk(q, 32'h0);
        chk({31'h0, e}, 32'h1);
        wr(RXAF_OFS_ADDR_LO, 32'h3322_1102);
        wr(RXAF_OFS_ADDR_HI, 32'h0000_5544);
        htab = 64'h0;
        htab[hidx(MCA)] = 1'b1;
        wr(RXAF_OFS_HASH_HI, htab[63:32]);
        wr(RXAF_OFS_HASH_LO, htab[31:0]);
        // every mode against station, other, multicast and broadcast
        foreach (ctls[m]) begin
            wr(RXAF_OFS_MAC_CTRL, {27'h0, ctls[m]});
            rd(RXAF_OFS_MAC_CTRL, {27'h0, ctls[m]});
            foreach (das[a])
                frame(das[a], ref_pass(ctls[m], das[a]), 1'b0);
        end
        // pass multicast so the pattern alone decides for group frames
        wr(RXAF_OFS_MAC_CTRL, 32'h10);
        foreach (wt[i]) begin
            load(wt[i].cmd, pcrc(14, 3) ^ {15'h0, wt[i].bad});
            wr(RXAF_OFS_WAKE_CSR, 32'h0000_000d);
            frame(wt[i].da, 1'b0, wt[i].hit);
            @(posedge pclk);
            chk({31'h0, host_irq}, {31'h0, wt[i].hit});
            chk({31'h0, power_event_out}, {31'h0, wt[i].hit});
            rd(RXAF_OFS_WAKE_CSR, {28'h0, 2'b11, wt[i].hit, 1'b1});
            wr(RXAF_OFS_WAKE_CSR, 32'h0000_0002);
            frame(STN, 1'b1, 1'b0);
        end
        reduced_power <= 1'b1;
        @(posedge pclk);
        rd(RXAF_OFS_WAKE_CSR, 32'h0000_0100);
        frame(STN, 1'b0, 1'b1);
        rd(RXAF_OFS_FRAME_STAT, {24'h0, hidx(STN), 2'b01});
        reduced_power <= 1'b0;
        end_of_test();
    end
endmodule
